/* logic/dfirq_pkg.sv */
// Package: register map, field positions, reset values of the deframer error slice
package dfirq_pkg;

    // Register indices; byte address is four times the index
    localparam logic [10:0] DFIRQ_IDX_CTRL_TWO = 11'h477;
    localparam logic [10:0] DFIRQ_IDX_ALIGN_LEN = 11'h478;
    localparam logic [10:0] DFIRQ_IDX_FLAGS_ENABLES = 11'h47A;
    localparam logic [10:0] DFIRQ_IDX_SYNC_SELECT = 11'h47B;
    localparam logic [10:0] DFIRQ_IDX_ERR_LIMIT = 11'h47C;
    localparam logic [10:0] DFIRQ_IDX_COUNT_CLEAR = 11'h480;

    // Byte address width and register data width
    localparam int DFIRQ_ADDR_W = 13;
    localparam int DFIRQ_DATA_W = 8;

    // Field positions, control register two
    localparam int DFIRQ_CT_TEST_LOOP_BIT = 7;
    localparam int DFIRQ_CT_THRESH_MASK_EN_BIT = 3;

    // Field positions, summary flags and irq enables
    localparam int DFIRQ_F_DISPARITY = 7;
    localparam int DFIRQ_F_TABLE_MISS = 6;
    localparam int DFIRQ_F_STRAY_CTRL = 5;
    localparam int DFIRQ_F_RESERVED = 4;
    localparam int DFIRQ_F_LANE_ALIGN = 3;
    localparam int DFIRQ_F_CHECKSUM = 2;
    localparam int DFIRQ_F_FRAME_LOCK = 1;
    localparam int DFIRQ_F_SYMBOL_LOCK = 0;

    // Field positions, sync request select
    localparam int DFIRQ_S_DISPARITY = 7;
    localparam int DFIRQ_S_TABLE_MISS = 6;
    localparam int DFIRQ_S_STRAY_CTRL = 5;

    // Reset values
    localparam logic [7:0] DFIRQ_RST_CTRL_TWO = 8'h00;
    localparam logic [7:0] DFIRQ_RST_ALIGN_LEN = 8'h01;
    localparam logic [7:0] DFIRQ_RST_ENABLES = 8'h00;
    localparam logic [7:0] DFIRQ_RST_SYNC_SELECT = 8'h00;
    localparam logic [7:0] DFIRQ_RST_ERR_LIMIT = 8'hFF;
    localparam logic [7:0] DFIRQ_RST_FLAGS = 8'h00;

    // Log2 of multiframes per unit of the align length field
    localparam int DFIRQ_ALIGN_UNIT_SHIFT = 2;

    // Clock figures
    localparam int DFIRQ_CLK_PERIOD_PS = 5000;
    localparam int DFIRQ_SYNC_STAGES = 2;

endpackage : dfirq_pkg

/* logic/dfirq_err_counter.sv */
// One saturating error counter with threshold compare
`timescale 1ns/10ps
`default_nettype none

module dfirq_err_counter
    import dfirq_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Event and control
    input wire logic hit,
    input wire logic clear,
    input wire logic [CNT_W-1:0] limit,
    // Status
    output logic reached_r,
    output logic [CNT_W-1:0] count_r
);

    logic [CNT_W-1:0] count_nxt; // Next count
    logic reached_nxt; // Next threshold state

    // Count events, hold at all ones, compare to shared limit
    always_comb
    begin
        count_nxt = count_r;
        if (clear)
        begin
            count_nxt = '0;
        end
        else if (hit && (count_r != {CNT_W{1'b1}}))
        begin
            count_nxt = count_r + 1'b1;
        end
        reached_nxt = (count_nxt >= limit);
    end

    // Register the counter
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            count_r <= '0;
            reached_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            reached_r <= reached_nxt;
        end
    end

endmodule : dfirq_err_counter

`default_nettype wire

/* logic/dfirq_top.sv */
// Deframer error summary, irq gating, sync request and align length control
// Notes on behaviour
// - Test loop bit set: expect endless align frames
// - Align length is four times field; resets 1
// - Flag 7: disparity count reached limit, any lane
// - Flag 6: table miss count reached limit
// - Flag 5: stray control count reached limit
// - Flag 3: lane align failed; bit 4 zero
// - Flag 2: bad checksum on some lane
// - Flag 1: frame lock failed on some lane
// - Flag 0: symbol lock failed on some lane
// - Enable 7 drives irq low on disparity
// - Enable 6 drives irq low on table miss
// - Enable 5 drives irq low on stray control
// - Enable 3 drives irq low on align fail
// - Enable 2 drives irq low on checksum
// - Enable 1 drives irq low on frame fail
// - Enable 0 drives irq low on symbol fail
// - Select 7 requests resync on disparity limit, only while control two bit 3 is set
// - All counts share one limit, reset FF
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module dfirq_top
    import dfirq_pkg::*;
#(
    parameter int NUM_LANES = 4,
    parameter int CNT_W = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [DFIRQ_ADDR_W-1:0] reg_addr,
    input wire logic [DFIRQ_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DFIRQ_DATA_W-1:0] reg_rdata,
    // Lane side, launched on rising edge of lane_clk
    input wire logic lane_clk,
    input wire logic [NUM_LANES-1:0] lane_disparity_err,
    input wire logic [NUM_LANES-1:0] lane_table_miss_err,
    input wire logic [NUM_LANES-1:0] lane_stray_ctrl_err,
    input wire logic [NUM_LANES-1:0] lane_align_fail,
    input wire logic [NUM_LANES-1:0] lane_checksum_fail,
    input wire logic [NUM_LANES-1:0] lane_frame_lock_fail,
    input wire logic [NUM_LANES-1:0] lane_symbol_lock_fail,
    // Interrupt and link outputs
    output logic irq_n,
    output logic link_resync_request_out,
    // Align sequence controls to the deframer
    output logic lane_align_test_loop,
    output logic [7:0] align_multiframe_quarter_count,
    output logic [9:0] align_sequence_length
);

    localparam int EV_N = 3 * NUM_LANES; // Counted event inputs
    localparam int LV_N = 4 * NUM_LANES; // Failure level inputs

    // Register address decode
    logic [10:0] reg_idx; // Register index
    logic addr_aligned; // Low address bits zero
    logic hit_ctrl; // Control register two
    logic hit_len; // Align length register
    logic hit_flags; // Flags and enables
    logic hit_sel; // Sync request select
    logic hit_limit; // Error limit
    logic hit_clr; // Counter clear strobe

    // Software visible state
    logic [7:0] ctrl_two_r; // Control register two
    logic [7:0] ctrl_two_nxt;
    logic [7:0] align_len_r; // Align length, quarter count
    logic [7:0] align_len_nxt;
    logic [7:0] irq_enables_r; // Write only irq enables
    logic [7:0] irq_enables_nxt;
    logic [7:0] sync_select_r; // Sync request select
    logic [7:0] sync_select_nxt;
    logic [7:0] err_limit_r; // Shared error limit
    logic [7:0] err_limit_nxt;
    logic [7:0] rdata_r; // Read data
    logic [7:0] rdata_nxt;
    logic count_clear_r; // Counter clear pulse
    logic count_clear_nxt;

    // Lane side synchroniser state
    logic [2:0] lck_r; // lane_clk stages plus history
    logic [EV_N-1:0] ev_s1_r; // First stage, events
    logic [EV_N-1:0] ev_s2_r; // Second stage, events
    logic [LV_N-1:0] lv_s1_r; // First stage, levels
    logic [LV_N-1:0] lv_s2_r; // Second stage, levels
    logic lck_fall; // Synchronised falling edge
    logic [EV_N-1:0] ev_hit; // One pulse per lane error

    // Summary state
    logic [EV_N-1:0] reached; // Per counter limit state
    logic [7:0] flags_r; // Summary flags
    logic [7:0] flags_nxt;
    logic irq_n_r; // Interrupt, active low
    logic irq_n_nxt;
    logic resync_r; // Resync request
    logic resync_nxt;

    // Decode of byte address into register index
    always_comb
    begin
        reg_idx = reg_addr[DFIRQ_ADDR_W-1:2];
        addr_aligned = (reg_addr[1:0] == 2'h0);
        hit_ctrl = addr_aligned && (reg_idx == DFIRQ_IDX_CTRL_TWO);
        hit_len = addr_aligned && (reg_idx == DFIRQ_IDX_ALIGN_LEN);
        hit_flags = addr_aligned && (reg_idx == DFIRQ_IDX_FLAGS_ENABLES);
        hit_sel = addr_aligned && (reg_idx == DFIRQ_IDX_SYNC_SELECT);
        hit_limit = addr_aligned && (reg_idx == DFIRQ_IDX_ERR_LIMIT);
        hit_clr = addr_aligned && (reg_idx == DFIRQ_IDX_COUNT_CLEAR);
    end

    // Register writes and read mux
    always_comb
    begin
        ctrl_two_nxt = ctrl_two_r;
        align_len_nxt = align_len_r;
        irq_enables_nxt = irq_enables_r;
        sync_select_nxt = sync_select_r;
        err_limit_nxt = err_limit_r;
        count_clear_nxt = 1'b0;
        rdata_nxt = 8'h00;
        if (reg_wr)
        begin
            // Writes store into the addressed register
            if (hit_ctrl)
            begin
                ctrl_two_nxt = reg_wdata;
            end
            if (hit_len)
            begin
                align_len_nxt = reg_wdata;
            end
            if (hit_flags)
            begin
                // Flags are read only; the write lands in the enables
                irq_enables_nxt = reg_wdata;
                irq_enables_nxt[DFIRQ_F_RESERVED] = 1'b0;
            end
            if (hit_sel)
            begin
                sync_select_nxt = reg_wdata;
            end
            if (hit_limit)
            begin
                err_limit_nxt = reg_wdata;
            end
            if (hit_clr)
            begin
                count_clear_nxt = reg_wdata[0];
            end
        end
        else if (reg_rd)
        begin
            // Reads return state; unmapped reads give zero
            if (hit_ctrl)
            begin
                rdata_nxt = ctrl_two_r;
            end
            else if (hit_len)
            begin
                rdata_nxt = align_len_r;
            end
            else if (hit_flags)
            begin
                rdata_nxt = flags_r;
            end
            else if (hit_sel)
            begin
                rdata_nxt = sync_select_r;
            end
            else if (hit_limit)
            begin
                rdata_nxt = err_limit_r;
            end
            else
            begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // Register file flip-flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_two_r <= DFIRQ_RST_CTRL_TWO;
            align_len_r <= DFIRQ_RST_ALIGN_LEN;
            irq_enables_r <= DFIRQ_RST_ENABLES;
            sync_select_r <= DFIRQ_RST_SYNC_SELECT;
            err_limit_r <= DFIRQ_RST_ERR_LIMIT;
            count_clear_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            ctrl_two_r <= ctrl_two_nxt;
            align_len_r <= align_len_nxt;
            irq_enables_r <= irq_enables_nxt;
            sync_select_r <= sync_select_nxt;
            err_limit_r <= err_limit_nxt;
            count_clear_r <= count_clear_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Two-stage synchronisers for the lane clock and all lane inputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            lck_r <= 3'h0;
            ev_s1_r <= '0;
            ev_s2_r <= '0;
            lv_s1_r <= '0;
            lv_s2_r <= '0;
        end
        else
        begin
            lck_r <= {lck_r[1:0], lane_clk};
            ev_s1_r <= {lane_stray_ctrl_err, lane_table_miss_err, lane_disparity_err};
            ev_s2_r <= ev_s1_r;
            lv_s1_r <= {lane_symbol_lock_fail, lane_frame_lock_fail,
                        lane_checksum_fail, lane_align_fail};
            lv_s2_r <= lv_s1_r;
        end
    end

    // Sample events mid lane cycle, away from their launch edge
    always_comb
    begin
        lck_fall = lck_r[2] && !lck_r[1];
        ev_hit = lck_fall ? ev_s2_r : '0;
    end

    // One counter per lane and error kind
    generate
        for (genvar gi = 0; gi < EV_N; gi++)
        begin : g_cnt
            dfirq_err_counter #(
                .CNT_W(CNT_W)
            ) u_cnt (
                .clk(clk),
                .rst_n(rst_n),
                .hit(ev_hit[gi]),
                .clear(count_clear_r),
                .limit(err_limit_r[CNT_W-1:0]),
                .reached_r(reached[gi]),
                .count_r()
            );
        end
    endgenerate

    // Summary flags, irq and resync request
    always_comb
    begin
        flags_nxt = DFIRQ_RST_FLAGS;
        flags_nxt[DFIRQ_F_DISPARITY] = |reached[NUM_LANES-1:0];
        flags_nxt[DFIRQ_F_TABLE_MISS] = |reached[2*NUM_LANES-1:NUM_LANES];
        flags_nxt[DFIRQ_F_STRAY_CTRL] = |reached[3*NUM_LANES-1:2*NUM_LANES];
        flags_nxt[DFIRQ_F_RESERVED] = 1'b0;
        flags_nxt[DFIRQ_F_LANE_ALIGN] = |lv_s2_r[NUM_LANES-1:0];
        flags_nxt[DFIRQ_F_CHECKSUM] = |lv_s2_r[2*NUM_LANES-1:NUM_LANES];
        flags_nxt[DFIRQ_F_FRAME_LOCK] = |lv_s2_r[3*NUM_LANES-1:2*NUM_LANES];
        flags_nxt[DFIRQ_F_SYMBOL_LOCK] = |lv_s2_r[4*NUM_LANES-1:3*NUM_LANES];
        // Any enabled flag pulls the line low
        irq_n_nxt = ~|(flags_r & irq_enables_r);
        // Select bits only act under the threshold mask enable
        resync_nxt = ctrl_two_r[DFIRQ_CT_THRESH_MASK_EN_BIT] && (
            (sync_select_r[DFIRQ_S_DISPARITY] && flags_r[DFIRQ_F_DISPARITY]) ||
            (sync_select_r[DFIRQ_S_TABLE_MISS] && flags_r[DFIRQ_F_TABLE_MISS]) ||
            (sync_select_r[DFIRQ_S_STRAY_CTRL] && flags_r[DFIRQ_F_STRAY_CTRL]));
    end

    // Summary flip-flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            flags_r <= DFIRQ_RST_FLAGS;
            irq_n_r <= 1'b1;
            resync_r <= 1'b0;
        end
        else
        begin
            flags_r <= flags_nxt;
            irq_n_r <= irq_n_nxt;
            resync_r <= resync_nxt;
        end
    end

    // Outputs
    always_comb
    begin
        reg_rdata = rdata_r;
        irq_n = irq_n_r;
        link_resync_request_out = resync_r;
        lane_align_test_loop = ctrl_two_r[DFIRQ_CT_TEST_LOOP_BIT];
        align_multiframe_quarter_count = align_len_r;
        align_sequence_length = {align_len_r, 2'h0};
    end

    // Checks on the behaviour above
    sequence s_limit_hit;
        flags_r[DFIRQ_F_DISPARITY] && sync_select_r[DFIRQ_S_DISPARITY]
            && ctrl_two_r[DFIRQ_CT_THRESH_MASK_EN_BIT];
    endsequence

    sequence s_len_write;
        reg_wr && hit_len;
    endsequence

    a_disparity_irq: assert property (@(posedge clk) disable iff (!rst_n)
        (irq_enables_r[DFIRQ_F_DISPARITY] && flags_r[DFIRQ_F_DISPARITY]) |=> !irq_n)
        else $error("irq not low on disparity flag");

    a_symbol_irq: assert property (@(posedge clk) disable iff (!rst_n)
        (irq_enables_r[DFIRQ_F_SYMBOL_LOCK] && flags_r[DFIRQ_F_SYMBOL_LOCK]) |=> !irq_n)
        else $error("irq not low on symbol lock flag");

    a_irq_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
        ((flags_r & irq_enables_r) == 8'h00) |=> irq_n)
        else $error("irq low with nothing enabled");

    a_resync_request: assert property (@(posedge clk) disable iff (!rst_n)
        s_limit_hit |=> link_resync_request_out)
        else $error("resync not requested at disparity limit");

    a_resync_gated: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_two_r[DFIRQ_CT_THRESH_MASK_EN_BIT] |=> !link_resync_request_out)
        else $error("resync without threshold mask enable");

    a_align_length: assert property (@(posedge clk) disable iff (!rst_n)
        s_len_write ##1 1'b1 |-> align_sequence_length == {$past(reg_wdata, 1), 2'h0})
        else $error("align length not four times field");

    a_lane_align_flag: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(|lv_s2_r[NUM_LANES-1:0]) |=> flags_r[DFIRQ_F_LANE_ALIGN])
            and (flags_r[DFIRQ_F_RESERVED] == 1'b0))
        else $error("lane align flag wrong");

    a_frame_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (|lv_s2_r[3*NUM_LANES-1:2*NUM_LANES]) |=> flags_r[DFIRQ_F_FRAME_LOCK])
        else $error("frame lock flag not set");

    a_flags_read: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && hit_flags) |=> (reg_rdata == $past(flags_r, 1)))
        else $error("flag read did not return flags");

    a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && hit_flags) |=> (irq_enables_r[7:5] == $past(reg_wdata[7:5], 1)))
        else $error("enable write lost");

    a_test_loop: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && hit_ctrl) |=> (lane_align_test_loop == $past(reg_wdata[7], 1)))
        else $error("test loop bit not followed");

    a_limit_reset: assert property (@(posedge clk)
        $rose(rst_n) |-> (err_limit_r == DFIRQ_RST_ERR_LIMIT))
        else $error("limit reset value wrong");

endmodule : dfirq_top

`default_nettype wire

/* testbench/dfirq_lane_model.sv */
// Link transmitter stand-in: lane clock and per-lane error strobes
`timescale 1ns/10ps
`default_nettype none

module dfirq_lane_model
#(
    parameter int NUM_LANES = 4,
    parameter real HALF_NS = 80.0
)
(
    // Link clock, still between bursts
    output logic lane_clk,
    // Per-lane error strobes
    output logic [NUM_LANES-1:0] lane_disparity_err,
    output logic [NUM_LANES-1:0] lane_table_miss_err,
    output logic [NUM_LANES-1:0] lane_stray_ctrl_err
);
    // Quiet link at time zero
    initial
    begin
        lane_clk = 1'b0;
        lane_disparity_err = '0;
        lane_table_miss_err = '0;
        lane_stray_ctrl_err = '0;
    end

    // Burst of n error periods on one lane, then one clean period
    task automatic send_errors(input int kind, input int lane, input int n);
        logic [NUM_LANES-1:0] v;
        for (int i = 0; i <= n; i++)
        begin
            v = '0;
            // Error launched with the rising edge, held the whole period
            if (i < n)
                v[lane] = 1'b1;
            // Deferred updates, so a change on a clk edge is seen after it
            lane_clk <= 1'b1;
            lane_disparity_err <= (kind == 0) ? v : '0;
            lane_table_miss_err <= (kind == 1) ? v : '0;
            lane_stray_ctrl_err <= (kind == 2) ? v : '0;
            #(HALF_NS);
            lane_clk <= 1'b0;
            #(HALF_NS);
        end
    endtask : send_errors
endmodule : dfirq_lane_model
`default_nettype wire

/* testbench/tb.sv */
// Testbench for the deframer error summary, irq and sync request slice
`timescale 1ns/10ps
`default_nettype none

// Compare, count, report a mismatch
`define DFIRQ_CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end

module tb
    import dfirq_pkg::*;
;
    // Clock and reset
    logic clk;
    logic rst_n;
    // Register port
    logic [DFIRQ_ADDR_W-1:0] reg_addr;
    logic [DFIRQ_DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DFIRQ_DATA_W-1:0] reg_rdata;
    // Lane side
    logic lane_clk;
    logic [3:0] lane_disparity_err;
    logic [3:0] lane_table_miss_err;
    logic [3:0] lane_stray_ctrl_err;
    logic [3:0] lane_align_fail;
    logic [3:0] lane_checksum_fail;
    logic [3:0] lane_frame_lock_fail;
    logic [3:0] lane_symbol_lock_fail;
    // Outputs
    logic irq_n;
    logic link_resync_request_out;
    logic lane_align_test_loop;
    logic [7:0] align_multiframe_quarter_count;
    logic [9:0] align_sequence_length;
    // Bookkeeping
    int bad_count;
    int samples_checked;
    logic [7:0] rd;

    // Block under test
    dfirq_top #(.NUM_LANES(4), .CNT_W(8)) dut_u (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_clk(lane_clk),
        .lane_disparity_err(lane_disparity_err), .lane_table_miss_err(lane_table_miss_err),
        .lane_stray_ctrl_err(lane_stray_ctrl_err), .lane_align_fail(lane_align_fail),
        .lane_checksum_fail(lane_checksum_fail), .lane_frame_lock_fail(lane_frame_lock_fail),
        .lane_symbol_lock_fail(lane_symbol_lock_fail), .irq_n(irq_n),
        .link_resync_request_out(link_resync_request_out),
        .lane_align_test_loop(lane_align_test_loop),
        .align_multiframe_quarter_count(align_multiframe_quarter_count),
        .align_sequence_length(align_sequence_length));

    // Transmitter stand-in
    dfirq_lane_model #(.NUM_LANES(4)) lm_u (
        .lane_clk(lane_clk), .lane_disparity_err(lane_disparity_err),
        .lane_table_miss_err(lane_table_miss_err), .lane_stray_ctrl_err(lane_stray_ctrl_err));

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Wait n edges, then let updates settle
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // One-cycle write strobe
    task automatic reg_write(input logic [10:0] idx, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= {idx, 2'b00};
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // One-cycle read strobe, data taken in the following cycle
    task automatic read_chk(input logic [10:0] idx, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= {idx, 2'b00};
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
        `DFIRQ_CHK($sformatf("reg %h", idx), exp, rd)
    endtask : read_chk

    // Failure level of one kind, launched at a clock edge
    task automatic set_fail(input int k, input logic [3:0] v);
        @(posedge clk);
        case (k)
            3: lane_align_fail <= v;
            2: lane_checksum_fail <= v;
            1: lane_frame_lock_fail <= v;
            default: lane_symbol_lock_fail <= v;
        endcase
    endtask : set_fail

    // Reset values and an unmapped place
    task automatic t_reset_vals();
        read_chk(DFIRQ_IDX_CTRL_TWO, 8'h00);
        read_chk(DFIRQ_IDX_ALIGN_LEN, 8'h01);
        read_chk(DFIRQ_IDX_FLAGS_ENABLES, 8'h00);
        read_chk(DFIRQ_IDX_SYNC_SELECT, 8'h00);
        read_chk(DFIRQ_IDX_ERR_LIMIT, 8'hFF);
        read_chk(11'h479, 8'h00);
        `DFIRQ_CHK("irq_n", 1'b1, irq_n)
        `DFIRQ_CHK("length", 10'h004, align_sequence_length)
        `DFIRQ_CHK("resync", 1'b0, link_resync_request_out)
    endtask : t_reset_vals

    // Test loop bit and align length field
    task automatic t_ctrl_align();
        logic [7:0] vals [3];
        vals = '{8'hFF, 8'h02, 8'h80};
        reg_write(DFIRQ_IDX_CTRL_TWO, 8'h80);
        wait_clk(1);
        `DFIRQ_CHK("test loop", 1'b1, lane_align_test_loop)
        reg_write(DFIRQ_IDX_CTRL_TWO, 8'h00);
        wait_clk(1);
        `DFIRQ_CHK("test loop", 1'b0, lane_align_test_loop)
        foreach (vals[i])
        begin
            // Nonzero lengths only
            reg_write(DFIRQ_IDX_ALIGN_LEN, vals[i]);
            wait_clk(1);
            `DFIRQ_CHK("quarter", vals[i], align_multiframe_quarter_count)
            `DFIRQ_CHK("length", {vals[i], 2'b00}, align_sequence_length)
            read_chk(DFIRQ_IDX_ALIGN_LEN, vals[i]);
        end
    endtask : t_ctrl_align

    // Level failures: flag, gating by enables, release
    task automatic t_levels();
        logic [7:0] fb;
        for (int k = 0; k < 4; k++)
        begin
            fb = 8'h01 << k;
            set_fail(k, 4'h1 << k);
            wait_clk(8);
            read_chk(DFIRQ_IDX_FLAGS_ENABLES, fb);
            `DFIRQ_CHK("irq_n", 1'b1, irq_n)
            reg_write(DFIRQ_IDX_FLAGS_ENABLES, ~fb);
            wait_clk(3);
            `DFIRQ_CHK("irq_n", 1'b1, irq_n)
            reg_write(DFIRQ_IDX_FLAGS_ENABLES, fb);
            wait_clk(3);
            `DFIRQ_CHK("irq_n", 1'b0, irq_n)
            read_chk(DFIRQ_IDX_FLAGS_ENABLES, fb);
            set_fail(k, 4'h0);
            wait_clk(8);
            `DFIRQ_CHK("irq_n", 1'b1, irq_n)
            read_chk(DFIRQ_IDX_FLAGS_ENABLES, 8'h00);
        end
        reg_write(DFIRQ_IDX_FLAGS_ENABLES, 8'h00);
    endtask : t_levels

    // Counted errors: one below the limit, then at it, then cleared
    task automatic t_counted();
        logic [7:0] fb;
        reg_write(DFIRQ_IDX_ERR_LIMIT, 8'h03);
        read_chk(DFIRQ_IDX_ERR_LIMIT, 8'h03);
        // Threshold mask enable set before select bits are used
        reg_write(DFIRQ_IDX_CTRL_TWO, 8'h08);
        for (int k = 0; k < 3; k++)
        begin
            fb = 8'h80 >> k;
            reg_write(DFIRQ_IDX_COUNT_CLEAR, 8'h01);
            reg_write(DFIRQ_IDX_FLAGS_ENABLES, fb);
            reg_write(DFIRQ_IDX_SYNC_SELECT, fb);
            lm_u.send_errors(k, k + 1, 2);
            wait_clk(10);
            read_chk(DFIRQ_IDX_FLAGS_ENABLES, 8'h00);
            `DFIRQ_CHK("irq_n", 1'b1, irq_n)
            `DFIRQ_CHK("resync", 1'b0, link_resync_request_out)
            lm_u.send_errors(k, k + 1, 1);
            wait_clk(10);
            read_chk(DFIRQ_IDX_FLAGS_ENABLES, fb);
            `DFIRQ_CHK("irq_n", 1'b0, irq_n)
            `DFIRQ_CHK("resync", 1'b1, link_resync_request_out)
            // Select bits idle without the threshold mask enable
            reg_write(DFIRQ_IDX_CTRL_TWO, 8'h00);
            wait_clk(2);
            `DFIRQ_CHK("resync gated", 1'b0, link_resync_request_out)
            `DFIRQ_CHK("irq_n gated", 1'b0, irq_n)
            reg_write(DFIRQ_IDX_CTRL_TWO, 8'h08);
            reg_write(DFIRQ_IDX_COUNT_CLEAR, 8'h01);
            wait_clk(4);
            read_chk(DFIRQ_IDX_FLAGS_ENABLES, 8'h00);
            `DFIRQ_CHK("irq_n", 1'b1, irq_n)
            `DFIRQ_CHK("resync", 1'b0, link_resync_request_out)
        end
        reg_write(DFIRQ_IDX_SYNC_SELECT, 8'h00);
        reg_write(DFIRQ_IDX_FLAGS_ENABLES, 8'h00);
    endtask : t_counted

    // Counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    // Main sequence
    initial
    begin
        bad_count = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        lane_align_fail = '0;
        lane_checksum_fail = '0;
        lane_frame_lock_fail = '0;
        lane_symbol_lock_fail = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_vals();
        t_ctrl_align();
        t_levels();
        t_counted();
        summarize();
    end

    // Hang guard, far beyond the expected run
    initial
    begin
        #200000;
        bad_count++;
        summarize();
    end
endmodule : tb
`default_nettype wire
